// file: pst_map.vh
// register map, field layout and timing names for the status and trim bank
// assumes: included by bare name from every design file of the bank
`ifndef PST_MAP_VH
`define PST_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PST_OFS_FAULT_MON 8'h00
`define PST_OFS_HEALTH 8'h01
`define PST_OFS_PIN_STATE 8'h02
`define PST_OFS_REV_GATE_CAL 8'h03
`define PST_OFS_LIMIT_SHARE 8'h04
`define PST_OFS_SHARE_OFS 8'h05

// ----------------------------------------------------------------
// nonvolatile source locations, trim values before download and the unmapped read value
// ----------------------------------------------------------------
`define PST_NVM_CAL 16'h8103
`define PST_NVM_LIMIT 16'h8104
`define PST_NVM_SHARE_OFS 16'h8105
`define PST_TRIM_RST 8'h00
`define PST_UNMAPPED_RD 8'h00

// ----------------------------------------------------------------
// calibration and current-sense fields
// ----------------------------------------------------------------
`define PST_CAL_REVOFF_HI 7
`define PST_CAL_REVOFF_LO 6
`define PST_CAL_REVON_HI 5
`define PST_CAL_REVON_LO 4
`define PST_CAL_GATEPEN 3
`define PST_CAL_GATERAMP 2
`define PST_CAL_LOV_HI 1
`define PST_CAL_LOV_LO 0
`define PST_LIM_LEVEL_HI 7
`define PST_LIM_LEVEL_LO 3
`define PST_LIM_WINDOW 2
`define PST_LIM_THRESH_HI 1
`define PST_LIM_THRESH_LO 0

// ----------------------------------------------------------------
// threshold decode, in millivolts
// ----------------------------------------------------------------
`define PST_REVOFF_BASE_MV 9'd100
`define PST_REVOFF_STEP_MV 9'd50
`define PST_REVON_BASE_MV 6'd20
`define PST_REVON_STEP_MV 6'd10
`define PST_SHARE_BASE_MV 9'd100
`define PST_SHARE_STEP_MV 9'd100

// ----------------------------------------------------------------
// timing and bus
// ----------------------------------------------------------------
`define PST_CLK_MHZ 100
`define PST_LOV_STEP_US 100
`define PST_SMB_ADDR 7'h2A

`endif

// file: pst_smb_host.sv
// bus host model: drives scl and the host side of the open-drain sda
// assumes: sda pulled up; scl stands high between frames
`timescale 1ns/1ps
`include "pst_map.vh"
module pst_smb_host (
    input logic sys_clk,
    input logic sda_oe,
    output logic scl,
    output logic sda,
    output logic rd_p,
    output logic [7:0] rd_byte,
    output logic nack
);
    logic sda_h = 1'b1;
    logic [7:0] q;
    logic a;
    // ----
    // wire, bits and frames
    // ----
    // the pull-up wins whenever no side pulls low
    assign sda = sda_h & ~sda_oe;
    initial begin
        scl = 1'b1;
        rd_p = 1'b0;
        nack = 1'b0;
    end
    // five clocks a half bit keeps both phases over the minimum
    task half;
        repeat (5) @(negedge sys_clk);
    endtask
    task bio(input logic b, output logic r);
        sda_h = b;
        half;
        scl = 1'b1;
        half;
        r = sda;
        scl = 1'b0;
    endtask
    task xfer(input logic [7:0] d, input logic m);
        for (int i = 7; i >= 0; i--) bio(d[i], q[i]);
        bio(m, a);
    endtask
    task start;
        sda_h = 1'b1;
        half;
        scl = 1'b1;
        half;
        sda_h = 1'b0;
        half;
        scl = 1'b0;
    endtask
    task stop;
        sda_h = 1'b0;
        half;
        scl = 1'b1;
        half;
        sda_h = 1'b1;
        half;
    endtask
    // every byte the host sends must be acked
    task put(input logic [7:0] d);
        xfer(d, 1'b1);
        nack |= a;
    endtask
    task wr(input logic [7:0] p, input logic [7:0] d);
        start;
        put({`PST_SMB_ADDR, 1'b0});
        put(p);
        put(d);
        stop;
    endtask
    // one byte, closed by a master nack
    task rd(input logic [7:0] p);
        start;
        put({`PST_SMB_ADDR, 1'b0});
        put(p);
        start;
        put({`PST_SMB_ADDR, 1'b1});
        xfer(8'hFF, 1'b1);
        rd_byte = q;
        stop;
        rd_p = 1'b1;
        @(negedge sys_clk);
        rd_p = 1'b0;
    endtask
endmodule

// file: pst_smb_phy.v
// serial management bus slave bit engine: start/stop, byte shift, ack slot
// assumes: scl and sda sampled synchronous to sys_clk, far faster than the bus;
// the byte layer answers ack_en, tx_en and tx_byte before the next scl fall
`timescale 1ns/1ps
`include "pst_map.vh"

module pst_smb_phy (
    input wire sys_clk,
    input wire arst_n,
    input wire scl_in,
    input wire sda_in,
    input wire ack_en,
    input wire tx_en,
    input wire [7:0] tx_byte,
    output reg sda_oe_r,
    output reg start_p_r,
    output reg stop_p_r,
    output reg rx_p_r,
    output reg [7:0] rx_byte_r,
    output reg mack_p_r
);

    reg scl_q_r;
    reg sda_q_r;
    reg busy_r;
    reg xmit_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    wire scl_rise;
    wire scl_fall;
    wire start_c;
    wire stop_c;
    wire [3:0] cnt_nxt;

    // ----------------------------------------------------------------
    // line events
    // ----------------------------------------------------------------
    assign scl_rise = scl_in & ~scl_q_r;
    assign scl_fall = ~scl_in & scl_q_r;
    assign start_c = scl_in & scl_q_r & sda_q_r & ~sda_in;
    assign stop_c = scl_in & scl_q_r & ~sda_q_r & sda_in;
    assign cnt_nxt = (cnt_r == 4'd8) ? 4'd0 : cnt_r + 4'd1;

    // bit engine; bit slot 8 is the acknowledge slot
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            busy_r <= 1'b0;
            xmit_r <= 1'b0;
            cnt_r <= 4'd0;
            sh_r <= 8'h00;
            sda_oe_r <= 1'b0;
            start_p_r <= 1'b0;
            stop_p_r <= 1'b0;
            rx_p_r <= 1'b0;
            rx_byte_r <= 8'h00;
            mack_p_r <= 1'b0;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
            start_p_r <= 1'b0;
            stop_p_r <= 1'b0;
            rx_p_r <= 1'b0;
            mack_p_r <= 1'b0;
            if (start_c) begin
                // repeated start also lands here
                busy_r <= 1'b1;
                xmit_r <= 1'b0;
                // 15 marks the start's own scl fall, which carries no bit
                cnt_r <= 4'hF;
                sda_oe_r <= 1'b0;
                start_p_r <= 1'b1;
            end else if (stop_c) begin
                busy_r <= 1'b0;
                sda_oe_r <= 1'b0;
                stop_p_r <= 1'b1;
            end else if (busy_r && scl_rise) begin
                if (cnt_r < 4'd8 && !xmit_r) begin
                    sh_r <= {sh_r[6:0], sda_in};
                end
                if (cnt_r == 4'd7 && !xmit_r) begin
                    rx_p_r <= 1'b1;
                    rx_byte_r <= {sh_r[6:0], sda_in};
                end
                if (cnt_r == 4'd8 && xmit_r) begin
                    // master nack ends our part of the frame
                    mack_p_r <= ~sda_in;
                    busy_r <= ~sda_in;
                end
            end else if (busy_r && scl_fall && cnt_r == 4'hF) begin
                cnt_r <= 4'd0;
            end else if (busy_r && scl_fall) begin
                cnt_r <= cnt_nxt;
                if (cnt_nxt == 4'd8) begin
                    sda_oe_r <= ~xmit_r & ack_en;
                end else if (cnt_nxt == 4'd0) begin
                    if (!xmit_r && !ack_en) begin
                        // not addressed or refused: stay off the line
                        busy_r <= 1'b0;
                        sda_oe_r <= 1'b0;
                    end else begin
                        xmit_r <= tx_en;
                        sh_r <= tx_byte;
                        sda_oe_r <= tx_en & ~tx_byte[7];
                    end
                end else begin
                    sda_oe_r <= xmit_r & ~sh_r[3'd7 - cnt_nxt[2:0]];
                end
            end
        end
    end

endmodule

// file: pst_status_trim.v
// status and trim register bank of a supply secondary-side controller
// assumes: one 100 MHz clock; all pins synchronous; nvm answers with one ack pulse
//
// Function
// - first status: overvoltage, undervoltage, timed overcurrent, five monitor flags.
// - second status bit 7 share within window, bit 6 isolating switch on.
// - second status bit 5: no reverse voltage seen across switch.
// - second status bits 4..0: supply, ground, internal, external reference, supply over.
// - third status bits 7..3: mains sense, power-on, primary enable, link, output good.
// - third status bit 2 follows overcurrent comparator directly, unlatched.
// - third status bit 1 pulses present, bit 0 fault latch.
// - status registers have no reset value except third status bit 5, which resets to 0; they read live conditions.
// - calibration bits 7-6 pick reverse turn-off threshold 100 to 250 mV.
// - calibration bits 5-4 pick reverse turn-on threshold 20 to 50 mV.
// - calibration bit 3 gates primary enable output with mains good.
// - calibration bit 2 gates soft-start ramp with mains good.
// - calibration bits 1-0 add 100 to 400 us load-overvoltage recovery delay.
// - current-sense bits 7-3 hold five-bit current-limit trim level.
// - current-sense bits 1-0 pick share window threshold 100 to 400 mV.
// - share offset is eight-bit trim, 00h minimum to FFh maximum.
// - trims load at power-up from nonvolatile 8103h, 8104h, 8105h.
`timescale 1ns/1ps
`include "pst_map.vh"

module pst_status_trim #(
    parameter SMB_ADDR = `PST_SMB_ADDR,
    parameter LOV_STEP_CYCLES = `PST_LOV_STEP_US * `PST_CLK_MHZ,
    parameter LOV_CNT_W = 16
) (
    input wire sys_clk,
    input wire arst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out_r,
    output wire sda_oe,
    output reg nvm_rd_r,
    output reg [15:0] nvm_addr_r,
    input wire nvm_ack,
    input wire [7:0] nvm_rdata,
    input wire overvoltage_fault,
    input wire undervoltage_fault,
    input wire overcurrent_timed_out,
    input wire [4:0] monitor_flags,
    input wire share_good,
    input wire isolating_switch_on,
    input wire reverse_ok,
    input wire supply_ok,
    input wire ground_ok,
    input wire int_ref_ok,
    input wire ext_ref_ok,
    input wire supply_over_ov,
    input wire mains_sense_good,
    input wire power_on_req,
    input wire link_state,
    input wire output_good,
    input wire overcurrent_now,
    input wire pulse_present,
    input wire fault_latch,
    input wire primary_enable_req,
    input wire ramp_req,
    input wire load_ov_clear,
    output reg primary_enable_output_r,
    output reg ramp_enable_r,
    output reg load_ov_recovered_r,
    output reg [8:0] rev_off_mv_r,
    output reg [5:0] rev_on_mv_r,
    output reg [8:0] share_window_mv_r,
    output reg [4:0] curr_limit_r,
    output reg share_window_bit_r,
    output wire [7:0] share_offset,
    output reg download_done_r
);

    localparam PH_IDLE = 2'd0, PH_ADDR = 2'd1, PH_CMD = 2'd2, PH_DATA = 2'd3;
    localparam SQ_REQ = 2'd0, SQ_WAIT = 2'd1, SQ_DONE = 2'd2;

    reg [1:0] ph_r, sq_r, sq_idx_r;
    reg [7:0] ptr_r, tx_byte_r;
    reg ack_en_r, tx_en_r, lov_prev_r;
    reg [LOV_CNT_W-1:0] lov_cnt_r;
    wire start_p, stop_p, rx_p, mack_p;
    wire [7:0] rx_byte, cal_q, lim_q, ofs_q;
    wire [7:0] st_fault, st_health, st_pins;
    wire [2:0] ld_p, wr_p;
    wire host_wr;
    wire [LOV_CNT_W-1:0] lov_target;

    // ----------------------------------------------------------------
    // live status words; no storage apart from the registered primary enable bit
    // ----------------------------------------------------------------
    assign st_fault = {overvoltage_fault, undervoltage_fault, overcurrent_timed_out,
                       monitor_flags};
    assign st_health = {share_good, isolating_switch_on,
                        reverse_ok,
                        supply_ok, ground_ok, int_ref_ok, ext_ref_ok, supply_over_ov};
    assign st_pins = {mains_sense_good, power_on_req, primary_enable_output_r,
                      link_state, output_good,
                      overcurrent_now,
                      pulse_present, fault_latch};

    // read mux; unmapped offsets read a fixed value
    function [7:0] rd_mux;
        input [7:0] ofs;
        begin
            case (ofs)
                `PST_OFS_FAULT_MON: rd_mux = st_fault;
                `PST_OFS_HEALTH: rd_mux = st_health;
                `PST_OFS_PIN_STATE: rd_mux = st_pins;
                `PST_OFS_REV_GATE_CAL: rd_mux = cal_q;
                `PST_OFS_LIMIT_SHARE: rd_mux = lim_q;
                `PST_OFS_SHARE_OFS: rd_mux = ofs_q;
                default: rd_mux = `PST_UNMAPPED_RD;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // bus bit engine
    // ----------------------------------------------------------------
    pst_smb_phy u_phy (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ack_en(ack_en_r),
        .tx_en(tx_en_r),
        .tx_byte(tx_byte_r),
        .sda_oe_r(sda_oe),
        .start_p_r(start_p),
        .stop_p_r(stop_p),
        .rx_p_r(rx_p),
        .rx_byte_r(rx_byte),
        .mack_p_r(mack_p)
    );

    // open drain: only ever pull low
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_out_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // byte layer: address, register pointer, data
    // ----------------------------------------------------------------
    // status offsets and unmapped offsets are acked but store nothing
    assign host_wr = rx_p & (ph_r == PH_DATA) & ~tx_en_r;
    assign wr_p[0] = host_wr & (ptr_r == `PST_OFS_REV_GATE_CAL);
    assign wr_p[1] = host_wr & (ptr_r == `PST_OFS_LIMIT_SHARE);
    assign wr_p[2] = host_wr & (ptr_r == `PST_OFS_SHARE_OFS);

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_r <= PH_IDLE;
            ptr_r <= 8'h00;
            ack_en_r <= 1'b0;
            tx_en_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else if (start_p) begin
            ph_r <= PH_ADDR;
            ack_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (stop_p) begin
            ph_r <= PH_IDLE;
            ack_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (rx_p) begin
            case (ph_r)
                PH_ADDR: begin
                    // no answer while the trims are still downloading
                    if (rx_byte[7:1] == SMB_ADDR[6:0] && download_done_r) begin
                        ack_en_r <= 1'b1;
                        tx_en_r <= rx_byte[0];
                        tx_byte_r <= rd_mux(ptr_r); // captured at address ack
                        ph_r <= rx_byte[0] ? PH_DATA : PH_CMD;
                    end else begin
                        ack_en_r <= 1'b0;
                        ph_r <= PH_IDLE;
                    end
                end
                PH_CMD: begin
                    ptr_r <= rx_byte;
                    ack_en_r <= 1'b1;
                    ph_r <= PH_DATA;
                end
                PH_DATA: begin
                    ack_en_r <= 1'b1;
                    ptr_r <= ptr_r + 8'h01;
                end
                default: begin
                    ack_en_r <= 1'b0;
                    ph_r <= PH_IDLE;
                end
            endcase
        end else if (mack_p) begin
            // master wants another byte: step pointer and fetch fresh data
            ptr_r <= ptr_r + 8'h01;
            tx_byte_r <= rd_mux(ptr_r + 8'h01);
        end
    end

    // ----------------------------------------------------------------
    // power-up download from nonvolatile memory
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sq_r <= SQ_REQ;
            sq_idx_r <= 2'd0;
            nvm_rd_r <= 1'b0;
            nvm_addr_r <= `PST_NVM_CAL;
            download_done_r <= 1'b0;
        end else begin
            nvm_rd_r <= 1'b0;
            case (sq_r)
                SQ_REQ: begin
                    nvm_rd_r <= 1'b1;
                    sq_r <= SQ_WAIT;
                end
                SQ_WAIT: begin
                    if (nvm_ack) begin
                        if (sq_idx_r == 2'd2) begin
                            sq_r <= SQ_DONE;
                            download_done_r <= 1'b1;
                        end else begin
                            sq_idx_r <= sq_idx_r + 2'd1;
                            nvm_addr_r <= (sq_idx_r == 2'd0) ? `PST_NVM_LIMIT
                                                              : `PST_NVM_SHARE_OFS;
                            sq_r <= SQ_REQ;
                        end
                    end
                end
                default: begin
                    sq_r <= SQ_DONE;
                end
            endcase
        end
    end

    // load strobe per trim, one per accepted nvm word
    assign ld_p = {3{(sq_r == SQ_WAIT) & nvm_ack}} & (3'b001 << sq_idx_r);

    // ----------------------------------------------------------------
    // trim registers
    // ----------------------------------------------------------------
    pst_trim_reg #(.WIDTH(8)) u_cal (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load_p(ld_p[0]),
        .load_data(nvm_rdata),
        .wr_p(wr_p[0]),
        .wr_data(rx_byte),
        .q_r(cal_q)
    );

    // bit 2 is kept only as storage for the analog comparator
    pst_trim_reg #(.WIDTH(8)) u_lim (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load_p(ld_p[1]),
        .load_data(nvm_rdata),
        .wr_p(wr_p[1]),
        .wr_data(rx_byte),
        .q_r(lim_q)
    );

    pst_trim_reg #(.WIDTH(8)) u_ofs (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load_p(ld_p[2]),
        .load_data(nvm_rdata),
        .wr_p(wr_p[2]),
        .wr_data(rx_byte),
        .q_r(ofs_q)
    );

    // share offset passes straight through; code is monotone in the analog dac
    assign share_offset = ofs_q;

    // ----------------------------------------------------------------
    // threshold decode and gating
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rev_off_mv_r <= `PST_REVOFF_BASE_MV;
            rev_on_mv_r <= `PST_REVON_BASE_MV;
            share_window_mv_r <= `PST_SHARE_BASE_MV;
            curr_limit_r <= 5'd0;
            share_window_bit_r <= 1'b0;
            primary_enable_output_r <= 1'b0;
            ramp_enable_r <= 1'b0;
        end else begin
            rev_off_mv_r <= `PST_REVOFF_BASE_MV + `PST_REVOFF_STEP_MV *
                {7'd0, cal_q[`PST_CAL_REVOFF_HI:`PST_CAL_REVOFF_LO]};
            rev_on_mv_r <= `PST_REVON_BASE_MV + `PST_REVON_STEP_MV *
                {4'd0, cal_q[`PST_CAL_REVON_HI:`PST_CAL_REVON_LO]};
            share_window_mv_r <= `PST_SHARE_BASE_MV + `PST_SHARE_STEP_MV *
                {7'd0, lim_q[`PST_LIM_THRESH_HI:`PST_LIM_THRESH_LO]};
            curr_limit_r <= lim_q[`PST_LIM_LEVEL_HI:`PST_LIM_LEVEL_LO];
            share_window_bit_r <= lim_q[`PST_LIM_WINDOW];
            primary_enable_output_r <= primary_enable_req &
                (~cal_q[`PST_CAL_GATEPEN] | mains_sense_good);
            ramp_enable_r <= ramp_req &
                (~cal_q[`PST_CAL_GATERAMP] | mains_sense_good);
        end
    end

    // ----------------------------------------------------------------
    // load overvoltage recovery delay
    // ----------------------------------------------------------------
    // delay is (code + 1) recovery steps
    assign lov_target = LOV_STEP_CYCLES[LOV_CNT_W-1:0] *
        ({{(LOV_CNT_W-2){1'b0}}, cal_q[`PST_CAL_LOV_HI:`PST_CAL_LOV_LO]} +
         {{(LOV_CNT_W-1){1'b0}}, 1'b1});

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lov_prev_r <= 1'b0;
            lov_cnt_r <= {LOV_CNT_W{1'b0}};
            load_ov_recovered_r <= 1'b0;
        end else begin
            lov_prev_r <= load_ov_clear;
            if (!load_ov_clear) begin
                lov_cnt_r <= {LOV_CNT_W{1'b0}};
                load_ov_recovered_r <= 1'b0;
            end else if (!lov_prev_r) begin
                lov_cnt_r <= {{(LOV_CNT_W-1){1'b0}}, 1'b1};
            end else if (!load_ov_recovered_r) begin
                if (lov_cnt_r >= lov_target) begin
                    load_ov_recovered_r <= 1'b1;
                end else begin
                    lov_cnt_r <= lov_cnt_r + {{(LOV_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

// file: pst_status_trim_monitor.sv
// checker on the bank's top-level ports
// assumes: one clock domain; bound at the foot
`timescale 1ns/1ps
module pst_status_trim_monitor (
    input logic sys_clk,
    input logic arst_n,
    input logic nvm_rd_r,
    input logic nvm_ack,
    input logic [15:0] nvm_addr_r,
    input logic primary_enable_req,
    input logic ramp_req,
    input logic mains_sense_good,
    input logic primary_enable_output_r,
    input logic ramp_enable_r,
    input logic [8:0] rev_off_mv_r,
    input logic [8:0] share_window_mv_r,
    input logic download_done_r
);
    // ----
    // gating, decode and download order
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // the extra past-reset term skips the first edge after release
    sequence s_pen;
        $past(arst_n) && $past(primary_enable_req) && $past(mains_sense_good);
    endsequence
    sequence s_ramp;
        $past(arst_n) && $past(ramp_req) && $past(mains_sense_good);
    endsequence
    sequence s_ack1;
        nvm_ack && nvm_addr_r == 16'h8103;
    endsequence
    sequence s_ack3;
        nvm_ack && nvm_addr_r == 16'h8105;
    endsequence
    AST_PEN_REQ: assert property (primary_enable_output_r |-> $past(primary_enable_req))
        else $error("enable out without request");
    AST_PEN_GATE: assert property (s_pen |-> primary_enable_output_r)
        else $error("enable blocked with mains good");
    AST_RAMP_GATE: assert property (s_ramp |-> ramp_enable_r)
        else $error("ramp blocked with mains good");
    AST_REV_OFF: assert property (rev_off_mv_r inside {9'h064, 9'h096, 9'h0C8, 9'h0FA})
        else $error("reverse off threshold off grid");
    AST_WINDOW: assert property (share_window_mv_r inside {9'h064, 9'h0C8, 9'h12C, 9'h190})
        else $error("share window off grid");
    AST_NVM_ADDR: assert property (nvm_rd_r |-> nvm_addr_r inside {16'h8103, 16'h8104, 16'h8105})
        else $error("nvm address out of range");
    AST_NVM_NEXT: assert property (s_ack1 |-> ##[1:3] (nvm_rd_r && nvm_addr_r == 16'h8104))
        else $error("second nvm request missing");
    AST_DONE: assert property (s_ack3 |-> ##[1:2] download_done_r)
        else $error("download not done");
endmodule
bind pst_status_trim pst_status_trim_monitor i_mon (.*);

// file: pst_status_trim_test.sv
// self-checking bench for the status and trim bank
// assumes: host model on the bus; nvm answered here
`timescale 1ns/1ps
module pst_status_trim_test;
    logic sys_clk = 1'b0, arst_n = 1'b0, nvm_ack = 1'b0, primary_enable_req = 1'b1;
    logic load_ov_clear = 1'b0, scl_in, sda_in, sda_out_r, sda_oe, nvm_rd_r, rd_p, nack;
    logic primary_enable_output_r, ramp_enable_r, load_ov_recovered_r;
    logic share_window_bit_r, download_done_r, overvoltage_fault, undervoltage_fault;
    logic overcurrent_timed_out, share_good, isolating_switch_on, reverse_ok, supply_ok;
    logic ground_ok, int_ref_ok, ext_ref_ok, supply_over_ov, mains_sense_good;
    logic power_on_req, ramp_req, link_state, output_good, overcurrent_now;
    logic pulse_present, fault_latch;
    logic [15:0] nvm_addr_r;
    logic [8:0] rev_off_mv_r, share_window_mv_r;
    logic [5:0] rev_on_mv_r;
    logic [4:0] curr_limit_r, monitor_flags;
    logic [7:0] nvm_rdata = 8'h00, st0 = 8'h00, st1 = 8'h00, st2 = 8'h00, r = 8'h2C;
    logic [7:0] share_offset, rd_byte;
    logic [7:0] nv [3] = '{8'hE6, 8'h5B, 8'h3C};
    logic [7:0] v [3] = '{8'hE6, 8'h5B, 8'h3C};
    logic [7:0] exp_q [$];
    int err_count = 0;
    int comparisons = 0, n = 0;
    // ----
    // wiring, clock and nvm
    // ----
    assign {overvoltage_fault, undervoltage_fault, overcurrent_timed_out, monitor_flags} = st0;
    assign {share_good, isolating_switch_on, reverse_ok, supply_ok, ground_ok, int_ref_ok,
        ext_ref_ok, supply_over_ov} = st1;
    assign {mains_sense_good, power_on_req, ramp_req, link_state, output_good,
        overcurrent_now, pulse_present, fault_latch} = st2;
    pst_status_trim #(.LOV_STEP_CYCLES(10)) i_dut (.*);
    pst_smb_host i_host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl_in), .sda(sda_in),
        .rd_p(rd_p), .rd_byte(rd_byte), .nack(nack));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // one-cycle ack; 8103h..8105h map to table slots 0..2
    always @(negedge sys_clk) begin
        nvm_ack <= nvm_rd_r;
        nvm_rdata <= nv[nvm_addr_r[1:0] + 2'h1];
    end
    // reads complete in order, so the oldest note is the one due
    always @(posedge rd_p) chk("read", exp_q.pop_front(), rd_byte);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task rdx(input logic [7:0] p, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.rd(p);
    endtask
    task dec;
        chk("rev_off", 9'h064 + 9'h032 * v[0][7:6], rev_off_mv_r);
        chk("rev_on", 6'h14 + 6'h0A * v[0][5:4], rev_on_mv_r);
        chk("limit", v[1][7:3], curr_limit_r);
        chk("win_bit", v[1][2], share_window_bit_r);
        chk("window", 9'h064 + 9'h064 * v[1][1:0], share_window_mv_r);
        chk("offset", v[2], share_offset);
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 100 && download_done_r !== 1'b1; i++) @(negedge sys_clk);
        if (download_done_r !== 1'b1) begin
            err_count++;
            end_sim;
        end
        dec;
        for (int i = 0; i < 3; i++) rdx(8'(3 + i), nv[i]);
        rdx(8'h07, 8'h00);
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            v[i % 3] = r;
            i_host.wr(8'(3 + i % 3), r);
            rdx(8'(3 + i % 3), r);
        end
        dec;
        load_ov_clear = 1'b1;
        for (n = 0; n < 60 && load_ov_recovered_r !== 1'b1; n++) @(negedge sys_clk);
        chk("recover", 16'd11 + 16'd10 * v[0][1:0], n);
        load_ov_clear = 1'b0;
        for (int i = 0; i < 4; i++) begin
            st0 = lfsr(r);
            st1 = lfsr(st0);
            st2 = lfsr(st1);
            r = lfsr(st2);
            i_host.wr(8'(i % 3), r);
            rdx(8'h00, st0);
            rdx(8'h01, st1);
            rdx(8'h02, {st2[7:6], ~v[0][3] | st2[7], st2[4:0]});
        end
        chk("nack", 1'b0, nack);
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        end_sim;
    end
endmodule

// file: pst_trim_reg.v
// one trim register: nvm load, then host writes
// assumes: load and write strobes are single-cycle and never coincide
`timescale 1ns/1ps
`include "pst_map.vh"

module pst_trim_reg #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire arst_n,
    input wire load_p,
    input wire [WIDTH-1:0] load_data,
    input wire wr_p,
    input wire [WIDTH-1:0] wr_data,
    output reg [WIDTH-1:0] q_r
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // download takes precedence should both ever arrive together
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= `PST_TRIM_RST;
        end else if (load_p) begin
            q_r <= load_data;
        end else if (wr_p) begin
            q_r <= wr_data;
        end
    end

endmodule
